/* pkg/lvl_prio_pkg.sv */
// constants, field layouts and carrier types for the level interrupt prioritizer
package lvl_prio_pkg;
	// --------
	// register byte offsets on the control bus
	// --------
	localparam logic [7:0] OFF_INT_CONTROL_ONE = 8'h00;
	localparam logic [7:0] OFF_PRIORITY_REG_A = 8'h04;
	localparam logic [7:0] OFF_PRIORITY_REG_B = 8'h08;
	localparam logic [7:0] OFF_PRIORITY_REG_D = 8'h0c;
	localparam logic [7:0] OFF_PRIORITY_REG_E = 8'h10;
	localparam logic [7:0] OFF_EVENT_CODE = 8'h14;
	localparam logic [7:0] OFF_EVENT_CODE_ALT = 8'h18;
	localparam logic [7:0] OFF_STATUS = 8'h1c;
	// --------
	// field positions and reset values
	// --------
	localparam int CTRL_LEVEL_MODE_BIT = 0;
	localparam int CTRL_SECOND_SET_BIT = 1;
	localparam logic [15:0] REG_RESET = 16'h0000;
	localparam logic [3:0] ENC_IDLE = 4'hf;
	localparam logic [3:0] LEVEL_TOP = 4'hf;
	localparam logic [3:0] LEVEL_NONE = 4'h0;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// --------
	// on-chip module request input positions
	// --------
	localparam int NUM_MOD = 10;
	localparam int MOD_TIMER = 0;
	localparam int MOD_RTC = 1;
	localparam int MOD_SER0 = 2;
	localparam int MOD_SER1 = 3;
	localparam int MOD_SER2 = 4;
	localparam int MOD_BUS = 5;
	localparam int MOD_WDT = 6;
	localparam int MOD_DMA = 7;
	localparam int MOD_ADC = 8;
	localparam int MOD_DBG = 9;
	// --------
	// arbitration slots, listed in fixed default order (0 wins ties)
	// --------
	localparam int NUM_SRC = 14;
	localparam int SLOT_DBG = 0;
	localparam int SLOT_ENC = 1;
	localparam int SLOT_PORT_LO = 2;
	localparam int SLOT_PORT_HI = 3;
	localparam int SLOT_DMA = 4;
	localparam int SLOT_SER1 = 5;
	localparam int SLOT_SER2 = 6;
	localparam int SLOT_ADC = 7;
	localparam int SLOT_TIMER = 8;
	localparam int SLOT_RTC = 9;
	localparam int SLOT_SER0 = 10;
	localparam int SLOT_BUS = 11;
	localparam int SLOT_WDT = 12;
	localparam int SLOT_SPARE = 13;
	// --------
	// per-source event codes
	// --------
	localparam logic [11:0] CODE_ENC_BASE = 12'h200;
	localparam logic [11:0] CODE_ENC_STEP = 12'h020;
	localparam logic [11:0] CODE_DBG = 12'h5e0;
	localparam logic [11:0] CODE_PORT_LO = 12'h700;
	localparam logic [11:0] CODE_PORT_HI = 12'h720;
	localparam logic [11:0] CODE_DMA = 12'h800;
	localparam logic [11:0] CODE_SER1 = 12'h880;
	localparam logic [11:0] CODE_SER2 = 12'h900;
	localparam logic [11:0] CODE_ADC = 12'h980;
	localparam logic [11:0] CODE_TIMER = 12'h400;
	localparam logic [11:0] CODE_RTC = 12'h480;
	localparam logic [11:0] CODE_SER0 = 12'h4e0;
	localparam logic [11:0] CODE_BUS = 12'h560;
	localparam logic [11:0] CODE_WDT = 12'h580;
	localparam logic [11:0] CODE_NONE = 12'h000;
	// --------
	// carrier for one arbitration result
	// --------
	typedef struct packed {
		logic valid;
		logic [3:0] level;
		logic [11:0] code;
	} pick_t;
endpackage

/* src/level_interrupt_source_prioritizer.sv */
// level interrupt source prioritizer with an axi4-lite register slave
//
// The AXI4-Lite slave port and the placing of the registers were decided locally.
`timescale 1ns/10ps
`default_nettype none

// Overview of operation
// [R1] both encoded buses level; second needs two enables
// [R2] take higher level of the two buses
// [R3] bus value v means level fifteen minus v
// [R4] accept encoded value after two equal samples
// [R5] standby filter steps on the rtc tick
// [R6] source must not lower level before acceptance
// [R7] acceptance never alters cpu mask level
// [R8] encoded request above mask wakes from standby
// [R9] port inputs level, two shared group priorities
// [R10] port 0/1 source holds level until accepted
// [R11] port 0/1 request above mask wakes standby
// [R12] collect ten on-chip module requests
// [R13] load unique code into both event registers
// [R14] module priority from fields, debug fixed 15
// [R15] timer or rtc above mask wakes standby
// [R16] level zero never forwarded
// [R17] reset sets all programmable priorities zero
// [R18] equal levels resolved by fixed default order
// [R19] signal cpu only when above mask level
// [R20] request pending while source level asserted
module level_interrupt_source_prioritizer (
	input wire logic i_sys_clk,
	input wire logic i_rst,
	// axi4-lite slave
	input wire logic i_awvalid,
	output logic o_awready,
	input wire logic [7:0] i_awaddr,
	input wire logic i_wvalid,
	output logic o_wready,
	input wire logic [31:0] i_wdata,
	input wire logic [3:0] i_wstrb,
	output logic o_bvalid,
	input wire logic i_bready,
	output logic [1:0] o_bresp,
	input wire logic i_arvalid,
	output logic o_arready,
	input wire logic [7:0] i_araddr,
	output logic o_rvalid,
	input wire logic i_rready,
	output logic [31:0] o_rdata,
	output logic [1:0] o_rresp,
	// request sources
	input wire logic [3:0] i_encoded_level_req_a,
	input wire logic [3:0] i_encoded_level_req_b,
	input wire logic [15:0] i_port_level_req,
	input wire logic [lvl_prio_pkg::NUM_MOD-1:0] i_module_req,
	// cpu core side
	input wire logic [3:0] i_cpu_mask_level,
	input wire logic i_int_accept,
	input wire logic i_standby,
	input wire logic i_rtc_tick,
	input wire logic i_rtc_osc_used,
	output logic o_int_req,
	output logic [3:0] o_int_level,
	output logic o_wakeup
);
	// --------
	// state
	// --------
	logic [15:0] int_control_one; // mode bits
	logic [15:0] priority_reg_a; // timer, rtc
	logic [15:0] priority_reg_b; // watchdog, bus, serial 0
	logic [15:0] priority_reg_d; // port groups
	logic [15:0] priority_reg_e; // dma, serial 1, serial 2, adc
	logic [11:0] event_code_reg; // code of last accepted source
	logic [11:0] event_code_alt_reg; // same code, second view
	logic [3:0] enc_raw [2]; // first sample of each encoded bus
	logic [3:0] enc_filt [2]; // accepted (filtered) bus values
	lvl_prio_pkg::pick_t pick; // registered arbitration winner
	lvl_prio_pkg::pick_t next_pick; // combinational winner
	logic [3:0] src_level [lvl_prio_pkg::NUM_SRC]; // effective level per slot
	logic [11:0] src_code [lvl_prio_pkg::NUM_SRC]; // event code per slot
	logic aw_held; // write address captured
	logic w_held; // write data captured
	logic [7:0] aw_addr; // captured write address
	logic [31:0] w_data; // captured write data
	logic [3:0] w_strb; // captured byte strobes
	logic sample_en; // filter sampling strobe
	logic second_en; // second encoded bus in use
	logic [3:0] lvl_a; // level decoded from bus a
	logic [3:0] lvl_b; // level decoded from bus b
	logic [3:0] enc_level; // combined encoded-bus level
	logic [3:0] port_lo_lvl; // level of ports 0-7
	logic [3:0] port_hi_lvl; // level of ports 8-15
	logic next_wakeup; // wake condition this cycle

	// --------
	// encoded bus filter
	// --------
	// in standby the peripheral clock is gone, so the filter only
	// steps on the 32 khz tick; no oscillator means no steps at all
	assign sample_en = i_standby ? (i_rtc_tick & i_rtc_osc_used) : 1'b1; // R5

	// two equal consecutive samples are needed before a value counts
	for (genvar b = 0; b < 2; b++) begin : g_filt
		logic [3:0] pin;
		assign pin = (b == 0) ? i_encoded_level_req_a : i_encoded_level_req_b;
		always_ff @(posedge i_sys_clk or posedge i_rst) begin
			if (i_rst) begin
				enc_raw[b] <= lvl_prio_pkg::ENC_IDLE;
				enc_filt[b] <= lvl_prio_pkg::ENC_IDLE;
			end else if (sample_en) begin
				enc_raw[b] <= pin; // R4
				if (pin == enc_raw[b]) begin
					enc_filt[b] <= pin; // R4
				end
			end
		end
	end

	// --------
	// level decode
	// --------
	// 0000 is the top level, 1111 decodes to level zero (nothing)
	assign lvl_a = lvl_prio_pkg::LEVEL_TOP - enc_filt[0]; // R3
	assign lvl_b = lvl_prio_pkg::LEVEL_TOP - enc_filt[1]; // R3
	assign second_en = int_control_one[lvl_prio_pkg::CTRL_LEVEL_MODE_BIT]
		& int_control_one[lvl_prio_pkg::CTRL_SECOND_SET_BIT]; // R1
	// the higher of the two buses wins when both are in use
	assign enc_level = (second_en && (lvl_b > lvl_a)) ? lvl_b : lvl_a; // R2
	// a group is pending while any of its pins is high
	assign port_lo_lvl = (|i_port_level_req[7:0]) ? priority_reg_d[15:12] :
		lvl_prio_pkg::LEVEL_NONE; // R9 R20
	assign port_hi_lvl = (|i_port_level_req[15:8]) ? priority_reg_d[11:8] :
		lvl_prio_pkg::LEVEL_NONE; // R9 R20

	// --------
	// source table, in default order
	// --------
	// a module slot shows its field (the debug slot its fixed level 15) while the request line is high
	function automatic logic [3:0] gate(input logic req, input logic [3:0] lvl);
		gate = req ? lvl : lvl_prio_pkg::LEVEL_NONE;
	endfunction

	always_comb begin
		src_level[lvl_prio_pkg::SLOT_DBG] = gate(i_module_req[lvl_prio_pkg::MOD_DBG],
			lvl_prio_pkg::LEVEL_TOP); // R14 R12
		src_level[lvl_prio_pkg::SLOT_ENC] = enc_level;
		src_level[lvl_prio_pkg::SLOT_PORT_LO] = port_lo_lvl;
		src_level[lvl_prio_pkg::SLOT_PORT_HI] = port_hi_lvl;
		src_level[lvl_prio_pkg::SLOT_DMA] = gate(i_module_req[lvl_prio_pkg::MOD_DMA],
			priority_reg_e[15:12]); // R14 R20
		src_level[lvl_prio_pkg::SLOT_SER1] = gate(i_module_req[lvl_prio_pkg::MOD_SER1],
			priority_reg_e[11:8]); // R14
		src_level[lvl_prio_pkg::SLOT_SER2] = gate(i_module_req[lvl_prio_pkg::MOD_SER2],
			priority_reg_e[7:4]); // R14
		src_level[lvl_prio_pkg::SLOT_ADC] = gate(i_module_req[lvl_prio_pkg::MOD_ADC],
			priority_reg_e[3:0]); // R14
		src_level[lvl_prio_pkg::SLOT_TIMER] = gate(i_module_req[lvl_prio_pkg::MOD_TIMER],
			priority_reg_a[15:12]); // R14
		src_level[lvl_prio_pkg::SLOT_RTC] = gate(i_module_req[lvl_prio_pkg::MOD_RTC],
			priority_reg_a[3:0]); // R14
		src_level[lvl_prio_pkg::SLOT_SER0] = gate(i_module_req[lvl_prio_pkg::MOD_SER0],
			priority_reg_b[7:4]); // R14
		src_level[lvl_prio_pkg::SLOT_BUS] = gate(i_module_req[lvl_prio_pkg::MOD_BUS],
			priority_reg_b[11:8]); // R14
		src_level[lvl_prio_pkg::SLOT_WDT] = gate(i_module_req[lvl_prio_pkg::MOD_WDT],
			priority_reg_b[15:12]); // R14
		src_level[lvl_prio_pkg::SLOT_SPARE] = lvl_prio_pkg::LEVEL_NONE;
		// encoded requests get a code per bus value, others a fixed one
		src_code[lvl_prio_pkg::SLOT_DBG] = lvl_prio_pkg::CODE_DBG; // R13
		src_code[lvl_prio_pkg::SLOT_ENC] = lvl_prio_pkg::CODE_ENC_BASE
			+ 12'(lvl_prio_pkg::LEVEL_TOP - enc_level) * lvl_prio_pkg::CODE_ENC_STEP; // R13
		src_code[lvl_prio_pkg::SLOT_PORT_LO] = lvl_prio_pkg::CODE_PORT_LO;
		src_code[lvl_prio_pkg::SLOT_PORT_HI] = lvl_prio_pkg::CODE_PORT_HI;
		src_code[lvl_prio_pkg::SLOT_DMA] = lvl_prio_pkg::CODE_DMA;
		src_code[lvl_prio_pkg::SLOT_SER1] = lvl_prio_pkg::CODE_SER1;
		src_code[lvl_prio_pkg::SLOT_SER2] = lvl_prio_pkg::CODE_SER2;
		src_code[lvl_prio_pkg::SLOT_ADC] = lvl_prio_pkg::CODE_ADC;
		src_code[lvl_prio_pkg::SLOT_TIMER] = lvl_prio_pkg::CODE_TIMER;
		src_code[lvl_prio_pkg::SLOT_RTC] = lvl_prio_pkg::CODE_RTC;
		src_code[lvl_prio_pkg::SLOT_SER0] = lvl_prio_pkg::CODE_SER0;
		src_code[lvl_prio_pkg::SLOT_BUS] = lvl_prio_pkg::CODE_BUS;
		src_code[lvl_prio_pkg::SLOT_WDT] = lvl_prio_pkg::CODE_WDT;
		src_code[lvl_prio_pkg::SLOT_SPARE] = lvl_prio_pkg::CODE_NONE;
	end

	// --------
	// arbitration
	// --------
	// strict greater-than keeps the earlier slot on a tie; a slot at
	// level zero can never beat the empty start value
	always_comb begin
		next_pick = '{valid: 1'b0, level: lvl_prio_pkg::LEVEL_NONE,
			code: lvl_prio_pkg::CODE_NONE};
		for (int s = 0; s < lvl_prio_pkg::NUM_SRC; s++) begin
			if (src_level[s] > next_pick.level) begin // R18 R16
				next_pick.valid = 1'b1;
				next_pick.level = src_level[s];
				next_pick.code = src_code[s];
			end
		end
	end

	// wake only with the 32 khz oscillator, from the listed sources
	always_comb begin
		next_wakeup = 1'b0;
		if (i_standby && i_rtc_osc_used) begin
			next_wakeup = (enc_level > i_cpu_mask_level) // R8
				|| ((|i_port_level_req[1:0]) && (priority_reg_d[15:12] > i_cpu_mask_level)) // R11
				|| (src_level[lvl_prio_pkg::SLOT_TIMER] > i_cpu_mask_level) // R15
				|| (src_level[lvl_prio_pkg::SLOT_RTC] > i_cpu_mask_level); // R15
		end
	end

	// --------
	// request to the cpu
	// --------
	// the mask level is only an input here; nothing in this block can
	// write it back, so acceptance leaves it as it was
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			pick <= '0;
			o_int_req <= 1'b0;
			o_int_level <= lvl_prio_pkg::LEVEL_NONE;
			o_wakeup <= 1'b0;
		end else begin
			pick <= next_pick;
			o_int_req <= next_pick.valid && (next_pick.level > i_cpu_mask_level); // R19 R7
			o_int_level <= next_pick.level;
			o_wakeup <= next_wakeup;
		end
	end

	// code of the request presented this cycle is kept on acceptance;
	// sources must hold their level until then, or the code may be stale
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			event_code_reg <= lvl_prio_pkg::CODE_NONE;
			event_code_alt_reg <= lvl_prio_pkg::CODE_NONE;
		end else if (i_int_accept && o_int_req) begin
			event_code_reg <= pick.code; // R13 R6 R10
			event_code_alt_reg <= pick.code; // R13
		end
	end

	// --------
	// axi4-lite write channel
	// --------
	function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d,
		input logic [3:0] st);
		merge = {st[1] ? d[15:8] : old[15:8], st[0] ? d[7:0] : old[7:0]};
	endfunction

	// address and data are caught in either order; the response
	// follows one cycle after both are held
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			o_awready <= 1'b1;
			o_wready <= 1'b1;
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= '0;
			w_data <= '0;
			w_strb <= '0;
			o_bvalid <= 1'b0;
			o_bresp <= lvl_prio_pkg::RESP_OKAY;
		end else begin
			if (i_awvalid && o_awready) begin
				aw_held <= 1'b1;
				aw_addr <= i_awaddr;
				o_awready <= 1'b0;
			end
			if (i_wvalid && o_wready) begin
				w_held <= 1'b1;
				w_data <= i_wdata;
				w_strb <= i_wstrb;
				o_wready <= 1'b0;
			end
			if (aw_held && w_held && !o_bvalid) begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				o_bvalid <= 1'b1;
				// read-only and unmapped words answer with an error
				unique case (aw_addr)
					lvl_prio_pkg::OFF_INT_CONTROL_ONE, lvl_prio_pkg::OFF_PRIORITY_REG_A,
					lvl_prio_pkg::OFF_PRIORITY_REG_B, lvl_prio_pkg::OFF_PRIORITY_REG_D,
					lvl_prio_pkg::OFF_PRIORITY_REG_E: begin
						o_bresp <= lvl_prio_pkg::RESP_OKAY;
					end
					default: begin
						o_bresp <= lvl_prio_pkg::RESP_SLVERR;
					end
				endcase
			end
			if (o_bvalid && i_bready) begin
				o_bvalid <= 1'b0;
				o_awready <= 1'b1;
				o_wready <= 1'b1;
			end
		end
	end

	// writable registers; only the low two byte lanes carry bits
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			int_control_one <= lvl_prio_pkg::REG_RESET;
			priority_reg_a <= lvl_prio_pkg::REG_RESET; // R17
			priority_reg_b <= lvl_prio_pkg::REG_RESET; // R17
			priority_reg_d <= lvl_prio_pkg::REG_RESET; // R17
			priority_reg_e <= lvl_prio_pkg::REG_RESET; // R17
		end else if (aw_held && w_held && !o_bvalid) begin
			unique case (aw_addr)
				lvl_prio_pkg::OFF_INT_CONTROL_ONE: begin
					int_control_one <= merge(int_control_one, w_data, w_strb); // R1
				end
				lvl_prio_pkg::OFF_PRIORITY_REG_A: begin
					priority_reg_a <= merge(priority_reg_a, w_data, w_strb);
				end
				lvl_prio_pkg::OFF_PRIORITY_REG_B: begin
					priority_reg_b <= merge(priority_reg_b, w_data, w_strb);
				end
				lvl_prio_pkg::OFF_PRIORITY_REG_D: begin
					priority_reg_d <= merge(priority_reg_d, w_data, w_strb); // R9
				end
				lvl_prio_pkg::OFF_PRIORITY_REG_E: begin
					priority_reg_e <= merge(priority_reg_e, w_data, w_strb);
				end
				default: begin
					// unmapped: nothing stored
				end
			endcase
		end
	end

	// --------
	// axi4-lite read channel
	// --------
	// one read at a time; arready drops until the data is taken
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			o_arready <= 1'b1;
			o_rvalid <= 1'b0;
			o_rdata <= '0;
			o_rresp <= lvl_prio_pkg::RESP_OKAY;
		end else if (i_arvalid && o_arready) begin
			o_arready <= 1'b0;
			o_rvalid <= 1'b1;
			o_rresp <= lvl_prio_pkg::RESP_OKAY;
			unique case (i_araddr)
				lvl_prio_pkg::OFF_INT_CONTROL_ONE: o_rdata <= {16'h0000, int_control_one};
				lvl_prio_pkg::OFF_PRIORITY_REG_A: o_rdata <= {16'h0000, priority_reg_a};
				lvl_prio_pkg::OFF_PRIORITY_REG_B: o_rdata <= {16'h0000, priority_reg_b};
				lvl_prio_pkg::OFF_PRIORITY_REG_D: o_rdata <= {16'h0000, priority_reg_d};
				lvl_prio_pkg::OFF_PRIORITY_REG_E: o_rdata <= {16'h0000, priority_reg_e};
				lvl_prio_pkg::OFF_EVENT_CODE: o_rdata <= {20'h00000, event_code_reg};
				lvl_prio_pkg::OFF_EVENT_CODE_ALT: o_rdata <= {20'h00000, event_code_alt_reg};
				// live state: winner, level, filtered bus values
				lvl_prio_pkg::OFF_STATUS: o_rdata <= {15'h0000, pick.valid, 4'h0,
					pick.level, enc_filt[1], enc_filt[0]};
				default: begin
					o_rdata <= '0;
					o_rresp <= lvl_prio_pkg::RESP_SLVERR;
				end
			endcase
		end else if (o_rvalid && i_rready) begin
			o_rvalid <= 1'b0;
			o_arready <= 1'b1;
		end
	end
endmodule // level_interrupt_source_prioritizer

`default_nettype wire

/* dv/lvl_prio_asserts.sv */
// port checker for the level interrupt prioritizer
`timescale 1ns/10ps
`default_nettype none
module lvl_prio_asserts (
	input wire logic i_sys_clk,
	input wire logic i_rst,
	input wire logic i_awvalid,
	input wire logic o_awready,
	input wire logic i_wvalid,
	input wire logic o_wready,
	input wire logic o_bvalid,
	input wire logic i_arvalid,
	input wire logic o_arready,
	input wire logic o_rvalid,
	input wire logic [3:0] i_encoded_level_req_a,
	input wire logic [3:0] i_encoded_level_req_b,
	input wire logic [15:0] i_port_level_req,
	input wire logic [lvl_prio_pkg::NUM_MOD-1:0] i_module_req,
	input wire logic [3:0] i_cpu_mask_level,
	input wire logic i_standby,
	input wire logic i_rtc_osc_used,
	input wire logic o_int_req,
	input wire logic [3:0] o_int_level,
	input wire logic o_wakeup
);
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (i_rst);
	// --------
	// sequences
	// --------
	// bus a held at the top code long enough to pass the filter
	sequence enc_top_held_s;
		(!i_standby && i_encoded_level_req_a == 4'h0 && i_cpu_mask_level != 4'hf) [*3];
	endsequence
	// all sources idle outside standby
	sequence all_quiet_s;
		(!i_standby && i_port_level_req == 16'h0000 && i_module_req == '0
			&& i_encoded_level_req_a == 4'hf && i_encoded_level_req_b == 4'hf) [*4];
	endsequence
	// --------
	// properties
	// --------
	req_above_mask_a: assert property (o_int_req |-> o_int_level > $past(i_cpu_mask_level))
		else $error("request raised at or below mask level");
	req_never_zero_a: assert property (o_int_req |-> o_int_level != 4'h0)
		else $error("request forwarded at level zero");
	wake_in_standby_a: assert property (o_wakeup |-> $past(i_standby && i_rtc_osc_used))
		else $error("wakeup outside standby or without slow oscillator");
	debug_fixed_top_a: assert property (!i_standby && i_module_req[lvl_prio_pkg::MOD_DBG]
		&& i_cpu_mask_level != 4'hf |=> o_int_req && o_int_level == 4'hf)
		else $error("debug request not at fixed top level");
	enc_filter_pass_a: assert property (enc_top_held_s |=> o_int_req && o_int_level == 4'hf)
		else $error("stable encoded request not accepted");
	quiet_no_req_a: assert property (all_quiet_s |=> !o_int_req)
		else $error("request stays with all sources idle");
	write_resp_a: assert property (i_awvalid && o_awready && i_wvalid && o_wready |-> ##2 o_bvalid)
		else $error("write response missing");
	read_resp_a: assert property (i_arvalid && o_arready |=> o_rvalid && !o_arready)
		else $error("read response missing");
endmodule // lvl_prio_asserts
bind level_interrupt_source_prioritizer lvl_prio_asserts lvl_prio_asserts_i (
	.i_sys_clk, .i_rst, .i_awvalid, .o_awready, .i_wvalid, .o_wready, .o_bvalid, .i_arvalid,
	.o_arready, .o_rvalid, .i_encoded_level_req_a, .i_encoded_level_req_b, .i_port_level_req,
	.i_module_req, .i_cpu_mask_level, .i_standby, .i_rtc_osc_used, .o_int_req, .o_int_level,
	.o_wakeup
);
`default_nettype wire

/* dv/cpu_partner.sv */
// cpu core model that accepts pending requests after a chosen delay
`timescale 1ns/10ps
`default_nettype none
module cpu_partner (
	input wire logic i_sys_clk,
	input wire logic i_rst,
	input wire logic i_int_req,
	input wire logic i_enable,
	input wire logic [1:0] i_delay,
	output logic o_int_accept
);
	logic [1:0] wait_cnt; // cycles left before accepting
	// accept pulse: one cycle, given only while the request still stands
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			wait_cnt <= 2'h0;
			o_int_accept <= 1'b0;
		end else if (o_int_accept || !i_int_req || !i_enable) begin
			wait_cnt <= i_delay; // reload so slow and prompt answers both occur
			o_int_accept <= 1'b0;
		end else if (wait_cnt != 2'h0) begin
			wait_cnt <= wait_cnt - 2'h1;
		end else begin
			o_int_accept <= 1'b1;
		end
	end
endmodule // cpu_partner
`default_nettype wire

/* dv/level_interrupt_source_prioritizer_bench.sv */
// self-checking bench for the level interrupt prioritizer
`timescale 1ns/10ps
`default_nettype none
module level_interrupt_source_prioritizer_bench;
	// programmable sources: field offset, field position, event code
	localparam logic [7:0] SRC_OFF [11] = '{8'h04, 8'h04, 8'h08, 8'h10, 8'h10, 8'h08, 8'h08,
		8'h10, 8'h10, 8'h0c, 8'h0c};
	localparam int SRC_SH [11] = '{12, 0, 4, 8, 4, 8, 12, 12, 0, 12, 8};
	localparam logic [11:0] SRC_CODE [11] = '{12'h400, 12'h480, 12'h4e0, 12'h880, 12'h900,
		12'h560, 12'h580, 12'h800, 12'h980, 12'h700, 12'h720};
	logic clk, rst, awvalid, wvalid, arvalid, bready, rready, standby, tick, osc, partner_on;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata, seed;
	logic [31:0] cyc = 32'h0; // cycle count, sole driver is the guard below
	logic [3:0] wstrb, enc_a, enc_b, mask, int_level;
	logic [15:0] port_req;
	logic [9:0] mod_req;
	logic [1:0] bresp, rresp, delay;
	logic awready, wready, bvalid, arready, rvalid, accept, int_req, wakeup;
	int err_count, n_tests;
	level_interrupt_source_prioritizer level_interrupt_source_prioritizer_i (
		.i_sys_clk(clk), .i_rst(rst), .i_awvalid(awvalid), .o_awready(awready),
		.i_awaddr(awaddr), .i_wvalid(wvalid), .o_wready(wready), .i_wdata(wdata),
		.i_wstrb(wstrb), .o_bvalid(bvalid), .i_bready(bready), .o_bresp(bresp),
		.i_arvalid(arvalid), .o_arready(arready), .i_araddr(araddr), .o_rvalid(rvalid),
		.i_rready(rready), .o_rdata(rdata), .o_rresp(rresp), .i_encoded_level_req_a(enc_a),
		.i_encoded_level_req_b(enc_b), .i_port_level_req(port_req), .i_module_req(mod_req),
		.i_cpu_mask_level(mask), .i_int_accept(accept), .i_standby(standby), .i_rtc_tick(tick),
		.i_rtc_osc_used(osc), .o_int_req(int_req), .o_int_level(int_level), .o_wakeup(wakeup));
	cpu_partner cpu_partner_i (.i_sys_clk(clk), .i_rst(rst), .i_int_req(int_req),
		.i_enable(partner_on), .i_delay(delay), .o_int_accept(accept));
	// --------
	// clock, rtc tick and hang guard
	// --------
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc <= cyc + 32'h1;
		tick <= (cyc[2:0] == 3'h0); // slow tick every eight cycles
		if (cyc == 32'd20000) begin
			err_count++;
			results();
		end
	end
	// --------
	// helpers
	// --------
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	// higher of the two decoded bus levels; bus b counts only with both enables
	function automatic logic [3:0] exp_enc(input logic [3:0] a, input logic [3:0] b,
		input logic [1:0] ctrl);
		logic [3:0] lb;
		lb = (ctrl == 2'h3) ? 4'hf - b : 4'h0;
		return (4'hf - a > lb) ? 4'hf - a : lb;
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic look(input logic r, input logic [3:0] l);
		chk({27'h0, int_req, int_level}, {27'h0, r, l});
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] er);
		@(posedge clk);
		awvalid <= 1'b1;
		awaddr <= a;
		wvalid <= 1'b1;
		wdata <= {seed[31:16], d}; // upper half must be ignored
		bready <= 1'b1;
		do begin
			@(posedge clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
		bready <= 1'b0;
		chk({30'h0, bresp}, {30'h0, er});
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
		@(posedge clk);
		arvalid <= 1'b1;
		araddr <= a;
		rready <= 1'b1;
		do begin
			@(posedge clk);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
		rready <= 1'b0;
		chk(rdata, exp);
		chk({30'h0, rresp}, {30'h0, er});
	endtask
	task automatic do_reset();
		rst <= 1'b1;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
	endtask
	task automatic results();
		if (err_count == 0 && n_tests > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	// --------
	// main sequence
	// --------
	initial begin
		logic [3:0] p;
		logic [3:0] b;
		{rst, awvalid, wvalid, arvalid, bready, rready, standby, osc, partner_on} = 9'h100;
		{awaddr, araddr, wdata, mod_req, port_req, mask, delay} = '0;
		{enc_a, enc_b, wstrb} = 12'hfff;
		seed = 32'h3;
		do_reset();
		for (int k = 0; k < 5; k++) rd(8'(k * 4), 32'h0, 2'h0);
		rd(8'h20, 32'h0, 2'h2);
		wr(8'h14, 16'h1234, 2'h2);
		// encoded buses under every enable combination, levels only rising
		for (int c = 0; c < 4; c++) begin
			do_reset();
			wr(8'h00, 16'(c), 2'h0);
			enc_b <= 4'h8;
			for (int v = 15; v >= 0; v--) begin
				enc_a <= 4'(v);
				repeat (4) @(posedge clk);
				look(exp_enc(4'(v), 4'h8, 2'(c)) != 4'h0, exp_enc(4'(v), 4'h8, 2'(c)));
			end
			enc_a <= 4'hf;
			enc_b <= 4'hf;
		end
		do_reset();
		enc_a <= 4'h0; // one-cycle glitch must be filtered out
		@(posedge clk);
		enc_a <= 4'hf;
		repeat (5) begin
			@(posedge clk);
			look(1'b0, 4'h0);
		end
		mod_req <= 10'h200;
		repeat (2) @(posedge clk);
		look(1'b1, 4'hf);
		rd(8'h1c, 32'h00010fff, 2'h0);
		partner_on <= 1'b1;
		repeat (8) @(posedge clk);
		rd(8'h14, 32'h5e0, 2'h0);
		mod_req <= 10'h0;
		partner_on <= 1'b0;
		// each programmable source: masked at zero, then strictly above mask
		for (int s = 0; s < 11; s++) begin
			p = 4'(rnd() % 15 + 1);
			b = 4'(rnd() % 8);
			delay <= b[1:0];
			if (s < 9) mod_req <= 10'(1 << s);
			else port_req <= 16'(1 << (b + (s - 9) * 8));
			mask <= p - 4'h1;
			repeat (3) @(posedge clk);
			look(1'b0, 4'h0);
			wr(SRC_OFF[s], 16'(p) << SRC_SH[s], 2'h0);
			repeat (2) @(posedge clk);
			look(1'b1, p);
			mask <= p;
			repeat (2) @(posedge clk);
			look(1'b0, p);
			mask <= p - 4'h1;
			partner_on <= 1'b1;
			repeat (8) @(posedge clk);
			rd(8'h14, {20'h0, SRC_CODE[s]}, 2'h0);
			rd(8'h18, {20'h0, SRC_CODE[s]}, 2'h0);
			{mod_req, port_req, partner_on} <= '0;
			repeat (2) @(posedge clk);
			look(1'b0, 4'h0);
		end
		// equal levels: default order decides
		mask <= 4'h0;
		wr(8'h04, 16'h5005, 2'h0);
		wr(8'h10, 16'h5005, 2'h0);
		wr(8'h0c, 16'h5000, 2'h0);
		mod_req <= 10'h183;
		partner_on <= 1'b1;
		repeat (8) @(posedge clk);
		rd(8'h14, 32'h800, 2'h0);
		mod_req <= 10'h003;
		repeat (8) @(posedge clk);
		rd(8'h14, 32'h400, 2'h0);
		{mod_req, partner_on} <= '0;
		// standby: slow filter needs the oscillator
		standby <= 1'b1;
		mask <= 4'h2;
		enc_a <= 4'h0;
		repeat (40) @(posedge clk);
		look(1'b0, 4'h0);
		chk({31'h0, wakeup}, 32'h0);
		osc <= 1'b1;
		repeat (40) @(posedge clk);
		chk({31'h0, wakeup}, 32'h1);
		enc_a <= 4'hf;
		repeat (40) @(posedge clk);
		mod_req <= 10'h002;
		repeat (3) @(posedge clk);
		chk({31'h0, wakeup}, 32'h1);
		mod_req <= 10'h0;
		port_req <= 16'h0002;
		repeat (3) @(posedge clk);
		chk({31'h0, wakeup}, 32'h1);
		osc <= 1'b0;
		repeat (3) @(posedge clk);
		chk({31'h0, wakeup}, 32'h0);
		results();
	end
endmodule // level_interrupt_source_prioritizer_bench
`default_nettype wire
